// ===== opdec_top.sv
`timescale 1ns/1ps
module opdec_top
    import opdec_pkg::*;
(
    input  wire logic                mclk,         // 100 MHz clock
    input  wire logic                rst_b,        // Async reset, low
    input  wire logic                opc_valid,    // Opcode byte present
    input  wire logic [7:0]          opc,          // Opcode byte
    input  wire logic [7:0]          op_reg,       // First operand byte
    input  wire logic [7:0]          op_b2,        // Second operand byte
    input  wire logic [15:0]         next_pc,      // Address after instr
    input  wire logic [15:0]         pair_value,   // Working pair contents
    output opdec_op_type             op_q,         // Decoded operation
    output opdec_mode_type           mode_q,       // Operand form
    output logic [1:0]               len_q,        // Operand byte count
    output logic                     valid_q,      // Decode result valid
    output logic                     undef_q,      // Undefined opcode
    output logic                     range_err_q,  // Operand out of range
    output logic                     pass_q,       // Passed to companion
    output logic [7:0]               pass_opc_q,   // Unchanged opcode
    output logic [15:0]              addr_q        // Target or address
);
    logic [1:0]     rst_sync_q;
    logic           rst_n;
    logic [3:0]     hi;
    logic [3:0]     lo;
    opdec_op_type   op_d;
    opdec_mode_type mode_d;
    logic           want_pair;
    logic           want_wpair;
    logic           fields_ok;
    logic [15:0]    addr_d;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    assign hi = opc[OPC_W-1:HI_LSB];
    assign lo = opc[NIB_W-1:0];

    always_comb
    begin
        op_d   = OP_NONE;
        mode_d = AM_NONE;
        if (int'(lo) <= LAST_COL)
        begin
            case (lo)
                4'h0, 4'h1:
                begin
                    mode_d = (lo == 4'h0) ? AM_R : AM_IR;
                    case (hi)
                        4'h0: op_d = OP_DEC;
                        4'h1: op_d = OP_ROTATE_LEFT_CARRY;
                        4'h2: op_d = OP_INC;
                        4'h3: op_d = OP_NONE;
                        4'h4: op_d = OP_DA;
                        4'h5: op_d = OP_POP;
                        4'h6: op_d = OP_COM;
                        4'h7: op_d = OP_PUSH;
                        4'h8: op_d = OP_WORD_DECREMENT;
                        4'h9: op_d = OP_RL;
                        4'hA: op_d = OP_WORD_INCREMENT;
                        4'hB: op_d = OP_CLR;
                        4'hC: op_d = OP_ROTATE_RIGHT_CARRY;
                        4'hD: op_d = OP_ARITH_SHIFT_RIGHT;
                        4'hE: op_d = OP_RR;
                        default: op_d = OP_SWAP;
                    endcase
                    if (opc == OPC_JUMP_IND)
                    begin
                        op_d   = OP_JUMP_INDIRECT;
                        mode_d = AM_IRR;
                    end
                    else if (opc == OPC_SET_RP)
                    begin
                        op_d   = OP_SET_REGISTER_POINTER;
                        mode_d = AM_IM;
                    end
                    else if (hi == 4'h8 && lo == 4'h0)
                        mode_d = AM_RR;
                    else if (hi == 4'hA && lo == 4'h0)
                        mode_d = AM_RR;
                end
                4'h7:
                begin
                    case (hi)
                        4'h0: op_d = OP_BIT_OR;
                        4'h1: op_d = OP_BIT_COMPARE;
                        4'h2: op_d = OP_BIT_EXCLUSIVE_OR;
                        4'h3: op_d = OP_BIT_TEST_JUMP_RELATIVE;
                        4'h4: op_d = OP_BIT_LOAD;
                        4'h5: op_d = OP_BIT_COMPLEMENT;
                        4'h6: op_d = OP_BIT_AND;
                        4'h7: op_d = OP_BIT_SET_CLEAR;
                        4'hA, 4'hB, 4'hE, 4'hF:
                              op_d = OP_PROGRAM_MEMORY_TRANSFER;
                        default: op_d = OP_LOAD;
                    endcase
                    case (hi)
                        4'h3: mode_d = AM_WBIT_REL;
                        4'h1: mode_d = AM_WBIT_R;
                        4'h0, 4'h2, 4'h4, 4'h6:
                              mode_d = AM_WBIT_R;
                        4'h5, 4'h7: mode_d = AM_WBIT;
                        4'h8, 4'h9: mode_d = AM_INDEXED;
                        4'hA, 4'hB: mode_d = AM_LONG_OFFSET_INDEXED;
                        4'hC, 4'hD: mode_d = AM_W_IW;
                        default: mode_d = AM_SHORT_OFFSET_INDEXED;
                    endcase
                end
                default:
                begin
                    case (lo)
                        4'h2: mode_d = AM_W_W;
                        4'h3: mode_d = AM_W_IW;
                        4'h4: mode_d = AM_R_R;
                        4'h5: mode_d = AM_IR_R;
                        default: mode_d = AM_R_IM;
                    endcase
                    case (hi)
                        4'h0: op_d = OP_ADD;
                        4'h1: op_d = OP_ADC;
                        4'h2: op_d = OP_SUB;
                        4'h3: op_d = OP_SBC;
                        4'h4: op_d = OP_OR;
                        4'h5: op_d = OP_AND;
                        4'h6: op_d = OP_COMPLEMENT_MASK_TEST;
                        4'h7: op_d = OP_MASK_TEST;
                        4'hA: op_d = OP_CP;
                        4'hB: op_d = OP_XOR;
                        default: op_d = OP_NONE;
                    endcase
                    case (opc)
                        8'h82: op_d = OP_USER_PUSH_DECREMENT;
                        8'h83: op_d = OP_USER_PUSH_INCREMENT;
                        8'h92: op_d = OP_USER_POP_DECREMENT;
                        8'h93: op_d = OP_USER_POP_INCREMENT;
                        8'h84, 8'h85, 8'h86: op_d = OP_MULT;
                        8'h94, 8'h95, 8'h96: op_d = OP_DIV;
                        8'hC2: op_d = OP_COMPARE_INC_JUMP_EQUAL;
                        8'hD2: op_d = OP_COMPARE_INC_JUMP_UNEQUAL;
                        8'hC3, 8'hD3: op_d = OP_PROGRAM_MEMORY_TRANSFER;
                        8'hE2: op_d = OP_PROGRAM_LOAD_DECREMENT;
                        8'hE3: op_d = OP_PROGRAM_LOAD_INCREMENT;
                        8'hF2: op_d = OP_PROGRAM_STORE_PREDECREMENT;
                        8'hF3: op_d = OP_PROGRAM_STORE_PREINCREMENT;
                        8'hC4, 8'hC5, 8'hC6: op_d = OP_WORD_LOAD;
                        8'hD4, 8'hF4, 8'hF6: op_d = OP_CALL;
                        8'hD6, 8'hE4, 8'hE5, 8'hE6, 8'hF5:
                              op_d = OP_LOAD;
                        OPC_UNDEF: op_d = OP_UNDEFINED;
                        default: op_d = op_d;
                    endcase
                    case (opc)
                        8'h82, 8'h83, 8'h92, 8'h93: mode_d = AM_IR_R;
                        8'h84, 8'h94: mode_d = AM_R_R;
                        8'h85, 8'h95: mode_d = AM_IR_R;
                        8'h86, 8'h96: mode_d = AM_IM_RR;
                        8'hC2, 8'hD2: mode_d = AM_IW_W_REL;
                        8'hC3, 8'hD3, 8'hE2, 8'hE3, 8'hF2, 8'hF3:
                              mode_d = AM_W_IWP;
                        8'hC4: mode_d = AM_RR;
                        8'hC5: mode_d = AM_IR_R;
                        8'hC6: mode_d = AM_IM_LONG;
                        8'hD4: mode_d = AM_IA;
                        8'hF4: mode_d = AM_IRR;
                        8'hF6: mode_d = AM_DA;
                        8'hD6: mode_d = AM_R_IM;
                        OPC_UNDEF: mode_d = AM_NONE;
                        default: mode_d = mode_d;
                    endcase
                end
            endcase
        end
    end

    assign want_pair  = mode_d == AM_RR || mode_d == AM_IRR ||
                        mode_d == AM_IM_RR;
    assign want_wpair = mode_d == AM_W_IWP ||
                        mode_d == AM_LONG_OFFSET_INDEXED ||
                        mode_d == AM_SHORT_OFFSET_INDEXED;

    opdec_fields u_fields
    (
        .reg_field  (op_reg),
        .wreg_field (op_reg[3:0]),
        .bit_field  (op_reg[6:4]),
        .want_pair  (want_pair),
        .want_wpair (want_wpair),
        .fields_ok  (fields_ok)
    );

    // Address arithmetic wraps at 16 bits, as program space does
    always_comb
    begin
        case (mode_d)
            AM_IW_W_REL, AM_WBIT_REL:
                addr_d = 16'(next_pc + {{8{op_b2[7]}}, op_b2});
            AM_SHORT_OFFSET_INDEXED:
                addr_d = 16'(pair_value + {{8{op_b2[7]}}, op_b2});
            AM_LONG_OFFSET_INDEXED:
                addr_d = 16'(pair_value + {op_b2, op_reg});
            AM_DA, AM_IM_LONG:
                addr_d = {op_reg, op_b2};
            AM_W_IWP:
                addr_d = pair_value;
            AM_R_IM, AM_IM:
                addr_d = {8'h00, op_b2};
            default:
                addr_d = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_q        <= OP_NONE;
            mode_q      <= AM_NONE;
            len_q       <= 2'h0;
            valid_q     <= 1'b0;
            undef_q     <= 1'b0;
            range_err_q <= 1'b0;
            addr_q      <= 16'h0000;
        end
        else
        begin
            valid_q     <= opc_valid && int'(lo) <= LAST_COL;
            op_q        <= opc_valid ? op_d : OP_NONE;
            mode_q      <= opc_valid ? mode_d : AM_NONE;
            len_q       <= opc_valid ? opdec_len(mode_d) : 2'h0;
            undef_q     <= opc_valid && opc == OPC_UNDEF;
            range_err_q <= opc_valid && !fields_ok;
            addr_q      <= addr_d;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pass_q     <= 1'b0;
            pass_opc_q <= 8'h00;
        end
        else
        begin
            pass_q     <= opc_valid && int'(lo) > LAST_COL;
            pass_opc_q <= opc;
        end
    end

    property p_high_cols_quiet;
        @(posedge mclk) disable iff (!rst_n)
        opc_valid && lo[3] |=> op_q == OP_NONE && pass_q && !valid_q;
    endproperty
    a_high_cols_quiet: assert property (p_high_cols_quiet)
        else $error("high column opcode produced an operation");

    property p_undef;
        @(posedge mclk) disable iff (!rst_n)
        opc_valid && opc == OPC_UNDEF |=> undef_q && op_q == OP_UNDEFINED;
    endproperty
    a_undef: assert property (p_undef)
        else $error("undefined opcode not flagged");

    property p_add_row;
        @(posedge mclk) disable iff (!rst_n)
        opc_valid && hi == 4'h0 && lo == 4'h2 |=>
            op_q == OP_ADD && mode_q == AM_W_W;
    endproperty
    a_add_row: assert property (p_add_row)
        else $error("row 0 column 2 not add register form");

    property p_imm_form;
        @(posedge mclk) disable iff (!rst_n)
        opc_valid && hi == 4'hB && lo == 4'h6 |=> mode_q == AM_R_IM;
    endproperty
    a_imm_form: assert property (p_imm_form)
        else $error("column 6 not immediate form");

    property p_jump_ind;
        @(posedge mclk) disable iff (!rst_n)
        opc_valid && opc == OPC_JUMP_IND |=> op_q == OP_JUMP_INDIRECT;
    endproperty
    a_jump_ind: assert property (p_jump_ind)
        else $error("jump through pair not decoded");

    property p_rel;
        @(posedge mclk) disable iff (!rst_n)
        opc_valid && lo == 4'h7 && hi == 4'h3 |=>
            addr_q == 16'($past(next_pc) + {{8{$past(op_b2[7])}},
                                           $past(op_b2)});
    endproperty
    a_rel: assert property (p_rel)
        else $error("relative target wrong");

    property p_mult;
        @(posedge mclk) disable iff (!rst_n)
        opc_valid && opc == 8'h86 |=> op_q == OP_MULT && len_q == 2'h2;
    endproperty
    a_mult: assert property (p_mult)
        else $error("multiply immediate not decoded");

    property p_odd_pair;
        @(posedge mclk) disable iff (!rst_n)
        opc_valid && opc == 8'hE3 && op_reg[0] |=> range_err_q;
    endproperty
    a_odd_pair: assert property (p_odd_pair)
        else $error("odd working pair not flagged");
endmodule : opdec_top

// ===== opdec_pkg.sv
package opdec_pkg;

    localparam int OPC_W     = 8;
    localparam int NIB_W     = 4;
    localparam int HI_LSB    = 4;
    localparam int LAST_COL  = 7;
    localparam int WREG_MAX  = 15;
    localparam int BIT_MAX   = 7;
    localparam int REG_MAX   = 255;
    localparam int PAIR_MAX  = 254;
    localparam int WPAIR_MAX = 14;
    localparam int DISP_MAX  = 127;
    localparam int DISP_MIN  = -128;
    localparam int WORD_MAX  = 65535;
    localparam int IMM_MAX   = 255;

    localparam logic [7:0] OPC_JUMP_IND  = 8'h30;
    localparam logic [7:0] OPC_SET_RP    = 8'h31;
    localparam logic [7:0] OPC_UNDEF     = 8'hD5;

    typedef enum logic [5:0] {
        OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_OR, OP_AND,
        OP_COMPLEMENT_MASK_TEST, OP_MASK_TEST, OP_CP, OP_XOR,
        OP_DEC, OP_ROTATE_LEFT_CARRY, OP_INC, OP_DA, OP_POP, OP_COM,
        OP_PUSH, OP_WORD_DECREMENT, OP_RL, OP_WORD_INCREMENT, OP_CLR,
        OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT, OP_RR, OP_SWAP,
        OP_JUMP_INDIRECT, OP_SET_REGISTER_POINTER,
        OP_USER_PUSH_DECREMENT, OP_USER_PUSH_INCREMENT,
        OP_USER_POP_DECREMENT, OP_USER_POP_INCREMENT, OP_MULT, OP_DIV,
        OP_COMPARE_INC_JUMP_EQUAL, OP_COMPARE_INC_JUMP_UNEQUAL,
        OP_PROGRAM_MEMORY_TRANSFER, OP_PROGRAM_LOAD_DECREMENT,
        OP_PROGRAM_LOAD_INCREMENT, OP_PROGRAM_STORE_PREDECREMENT,
        OP_PROGRAM_STORE_PREINCREMENT, OP_WORD_LOAD, OP_CALL, OP_LOAD,
        OP_BIT_OR, OP_BIT_COMPARE, OP_BIT_EXCLUSIVE_OR,
        OP_BIT_TEST_JUMP_RELATIVE, OP_BIT_LOAD, OP_BIT_COMPLEMENT,
        OP_BIT_AND, OP_BIT_SET_CLEAR, OP_UNDEFINED
    } opdec_op_type;

    typedef enum logic [4:0] {
        AM_NONE, AM_R, AM_IR, AM_RR, AM_IRR, AM_W_W, AM_W_IW, AM_R_R,
        AM_IR_R, AM_R_IM, AM_IM, AM_IM_RR, AM_IRR_IW, AM_IW_W_REL,
        AM_W_IWP, AM_IM_LONG, AM_IA, AM_DA, AM_WBIT, AM_WBIT_REL,
        AM_WBIT_R, AM_INDEXED, AM_LONG_OFFSET_INDEXED,
        AM_SHORT_OFFSET_INDEXED
    } opdec_mode_type;

    // Byte count of operand bytes after the opcode for each form
    function automatic logic [1:0] opdec_len(input opdec_mode_type m);
        case (m)
            AM_NONE:                 opdec_len = 2'h0;
            AM_LONG_OFFSET_INDEXED,
            AM_IM_LONG, AM_DA,
            AM_R_IM, AM_IW_W_REL,
            AM_WBIT_REL, AM_INDEXED,
            AM_IM_RR:                opdec_len = 2'h2;
            default:                 opdec_len = 2'h1;
        endcase
    endfunction : opdec_len

endpackage : opdec_pkg

// ===== opdec_fields.sv
`timescale 1ns/1ps
// Range classifier for operand fields, kept apart from the map decode
module opdec_fields
    import opdec_pkg::*;
(
    input  wire logic [7:0]  reg_field,   // Register or pair number
    input  wire logic [3:0]  wreg_field,  // Working register number
    input  wire logic [2:0]  bit_field,   // Bit index
    input  wire logic        want_pair,   // Field names a pair
    input  wire logic        want_wpair,  // Working field names a pair
    output logic             fields_ok    // Fields within legal range
);
    logic pair_ok;
    logic wpair_ok;

    always_comb
    begin
        pair_ok  = !want_pair || (reg_field[0] == 1'b0 &&
                   int'(reg_field) <= PAIR_MAX);
        wpair_ok = !want_wpair || (wreg_field[0] == 1'b0 &&
                   int'(wreg_field) <= WPAIR_MAX);
        fields_ok = pair_ok && wpair_ok &&
                    int'(bit_field) <= BIT_MAX &&
                    int'(wreg_field) <= WREG_MAX;
    end
endmodule : opdec_fields

// ===== opdec_fetch_model.sv
`timescale 1ns/1ps
// Fetch path: presents opcode bytes while present is high
module opdec_fetch_model
    import opdec_pkg::*;
(
    input  wire logic       mclk,      // Clock
    input  wire logic       present,   // Bytes on the fetch bus
    input  wire logic [7:0] f_opc,     // Opcode to present
    input  wire logic [7:0] f_reg,     // First operand byte
    input  wire logic [7:0] f_b2,      // Second operand byte
    output logic            opc_valid, // Opcode present
    output logic [7:0]      opc,       // Opcode byte
    output logic [7:0]      op_reg,    // First operand byte
    output logic [7:0]      op_b2      // Second operand byte
);
    logic [23:0] last_q;

    always_ff @(posedge mclk)
    begin
        if (present)
            last_q <= {f_opc, f_reg, f_b2};
    end

    // Released bus shows the inverse so a stale byte is never decoded
    assign opc_valid = present;
    assign {opc, op_reg, op_b2} = present ? {f_opc, f_reg, f_b2} : ~last_q;
endmodule : opdec_fetch_model

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import opdec_pkg::*;
    typedef struct {
        logic [7:0] opc, rg, b2;
        opdec_op_type op;
        logic [15:0] addr;
        int chka;
    } row_type;
    logic mclk = 1'b0, rst_b = 1'b0, present = 1'b0;
    logic [7:0] f_opc = 8'h00, f_reg = 8'h00, f_b2 = 8'h00;
    logic [15:0] next_pc = 16'h1000, pair_value = 16'h2000;
    logic opc_valid, valid_q, undef_q, range_err_q, pass_q;
    logic [7:0] opc, op_reg, op_b2, pass_opc_q;
    logic [1:0] len_q;
    logic [15:0] addr_q;
    opdec_op_type op_q;
    opdec_mode_type mode_q;
    int num_errors = 0, cmp_count = 0;
    opdec_op_type two_op[10] = '{OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_OR,
        OP_AND, OP_COMPLEMENT_MASK_TEST, OP_MASK_TEST, OP_CP, OP_XOR};
    logic [3:0] two_row[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
        4'h6, 4'h7, 4'hA, 4'hB};
    opdec_mode_type two_md[5] = '{AM_W_W, AM_W_IW, AM_R_R, AM_IR_R,
        AM_R_IM};
    opdec_op_type one_op[16] = '{OP_DEC, OP_ROTATE_LEFT_CARRY, OP_INC,
        OP_NONE, OP_DA, OP_POP, OP_COM, OP_PUSH, OP_WORD_DECREMENT, OP_RL,
        OP_WORD_INCREMENT, OP_CLR, OP_ROTATE_RIGHT_CARRY,
        OP_ARITH_SHIFT_RIGHT, OP_RR, OP_SWAP};
    row_type rows[] = '{
        '{8'h30, 8'h24, 8'h00, OP_JUMP_INDIRECT, 16'h0, 0},
        '{8'h31, 8'h24, 8'h00, OP_SET_REGISTER_POINTER, 16'h0, 0},
        '{8'h82, 8'h24, 8'h00, OP_USER_PUSH_DECREMENT, 16'h0, 0},
        '{8'h83, 8'h24, 8'h00, OP_USER_PUSH_INCREMENT, 16'h0, 0},
        '{8'h92, 8'h24, 8'h00, OP_USER_POP_DECREMENT, 16'h0, 0},
        '{8'h93, 8'h24, 8'h00, OP_USER_POP_INCREMENT, 16'h0, 0},
        '{8'h84, 8'h24, 8'h00, OP_MULT, 16'h0, 0},
        '{8'h96, 8'h24, 8'h00, OP_DIV, 16'h0, 0},
        '{8'hD2, 8'h24, 8'h80, OP_COMPARE_INC_JUMP_UNEQUAL, 16'h0F80, 1},
        '{8'hC2, 8'h24, 8'h7F, OP_COMPARE_INC_JUMP_EQUAL, 16'h107F, 1},
        '{8'hD3, 8'h24, 8'h00, OP_PROGRAM_MEMORY_TRANSFER, 16'h0, 0},
        '{8'hE2, 8'h24, 8'h00, OP_PROGRAM_LOAD_DECREMENT, 16'h0, 0},
        '{8'hF3, 8'h24, 8'h00, OP_PROGRAM_STORE_PREINCREMENT, 16'h0, 0},
        '{8'hC6, 8'h24, 8'h00, OP_WORD_LOAD, 16'h2400, 1},
        '{8'hD4, 8'h24, 8'h00, OP_CALL, 16'h0, 0},
        '{8'hF6, 8'h12, 8'h34, OP_CALL, 16'h1234, 1},
        '{8'hE5, 8'h24, 8'h00, OP_LOAD, 16'h0, 0},
        '{8'h07, 8'h24, 8'h00, OP_BIT_OR, 16'h0, 0},
        '{8'h17, 8'h24, 8'h00, OP_BIT_COMPARE, 16'h0, 0},
        '{8'h27, 8'h24, 8'h00, OP_BIT_EXCLUSIVE_OR, 16'h0, 0},
        '{8'h37, 8'h24, 8'hFE, OP_BIT_TEST_JUMP_RELATIVE, 16'h0FFE, 1},
        '{8'h47, 8'h24, 8'h00, OP_BIT_LOAD, 16'h0, 0},
        '{8'h57, 8'h24, 8'h00, OP_BIT_COMPLEMENT, 16'h0, 0},
        '{8'h67, 8'h24, 8'h00, OP_BIT_AND, 16'h0, 0},
        '{8'h77, 8'h24, 8'h00, OP_BIT_SET_CLEAR, 16'h0, 0},
        '{8'hA7, 8'h34, 8'h12, OP_PROGRAM_MEMORY_TRANSFER, 16'h3234, 1},
        '{8'hE7, 8'h24, 8'hFF, OP_PROGRAM_MEMORY_TRANSFER, 16'h1FFF, 1},
        '{8'h86, 8'h24, 8'h00, OP_MULT, 16'h0, 0},
        '{8'h85, 8'h24, 8'h00, OP_MULT, 16'h0, 0},
        '{8'h94, 8'h24, 8'h00, OP_DIV, 16'h0, 0},
        '{8'h95, 8'h24, 8'h00, OP_DIV, 16'h0, 0},
        '{8'hC3, 8'h24, 8'h00, OP_PROGRAM_MEMORY_TRANSFER, 16'h2000, 1},
        '{8'hE3, 8'h24, 8'h00, OP_PROGRAM_LOAD_INCREMENT, 16'h0, 0},
        '{8'hF2, 8'h24, 8'h00, OP_PROGRAM_STORE_PREDECREMENT, 16'h0, 0},
        '{8'hC4, 8'h24, 8'h00, OP_WORD_LOAD, 16'h0, 0},
        '{8'hC5, 8'h24, 8'h00, OP_WORD_LOAD, 16'h0, 0},
        '{8'hF4, 8'h24, 8'h00, OP_CALL, 16'h0, 0},
        '{8'hD6, 8'h24, 8'hA5, OP_LOAD, 16'h00A5, 1},
        '{8'hE4, 8'h24, 8'h00, OP_LOAD, 16'h0, 0},
        '{8'hE6, 8'h24, 8'h3C, OP_LOAD, 16'h003C, 1},
        '{8'hF5, 8'h24, 8'h00, OP_LOAD, 16'h0, 0},
        '{8'h87, 8'h24, 8'h00, OP_LOAD, 16'h0, 0},
        '{8'h97, 8'h24, 8'h00, OP_LOAD, 16'h0, 0},
        '{8'hB7, 8'h36, 8'hFF, OP_PROGRAM_MEMORY_TRANSFER, 16'h1F36, 1},
        '{8'hF7, 8'h26, 8'h80, OP_PROGRAM_MEMORY_TRANSFER, 16'h1F80, 1},
        '{8'hC7, 8'h24, 8'h00, OP_LOAD, 16'h0, 0},
        '{8'hD7, 8'h24, 8'h00, OP_LOAD, 16'h0, 0}};

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    opdec_fetch_model u_opdec_fetch_model (.mclk(mclk), .present(present),
        .f_opc(f_opc), .f_reg(f_reg), .f_b2(f_b2), .opc_valid(opc_valid),
        .opc(opc), .op_reg(op_reg), .op_b2(op_b2));

    opdec_top u_opdec_top (.mclk(mclk), .rst_b(rst_b),
        .opc_valid(opc_valid), .opc(opc), .op_reg(op_reg), .op_b2(op_b2),
        .next_pc(next_pc), .pair_value(pair_value), .op_q(op_q),
        .mode_q(mode_q), .len_q(len_q), .valid_q(valid_q),
        .undef_q(undef_q), .range_err_q(range_err_q), .pass_q(pass_q),
        .pass_opc_q(pass_opc_q), .addr_q(addr_q));

    task automatic chk(input string nm, input logic [15:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    // Present one opcode; result is registered on the taking edge and read 1 ns after it
    task automatic send(input logic [7:0] o, r, b);
        @(posedge mclk);
        present <= 1'b1;
        f_opc <= o;
        f_reg <= r;
        f_b2 <= b;
        @(posedge mclk);
        present <= 1'b0;
        #1;
    endtask : send

    task automatic good(input opdec_op_type op);
        chk("op", 16'(op_q), 16'(op));
        chk("valid", 16'(valid_q), 16'h1);
        chk("pass", 16'(pass_q), 16'h0);
        chk("range", 16'(range_err_q), 16'h0);
    endtask : good

    task automatic end_sim;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    initial
    begin
        #50000;
        num_errors++;
        end_sim();
    end

    initial
    begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        foreach (rows[i])
        begin
            send(rows[i].opc, rows[i].rg, rows[i].b2);
            good(rows[i].op);
            if (rows[i].chka)
                chk("addr", addr_q, rows[i].addr);
        end
        foreach (two_row[r])
            for (int c = 2; c <= 6; c++)
            begin
                send({two_row[r], 4'(c)}, 8'h24, 8'h5A);
                good(two_op[r]);
                chk("mode", 16'(mode_q), 16'(two_md[c - 2]));
            end
        for (int r = 0; r < 16; r++)
            for (int c = 0; c < 2; c++)
                if (r != 3)
                begin
                    send({4'(r), 4'(c)}, 8'h24, 8'h00);
                    good(one_op[r]);
                    chk("mode", 16'(mode_q), (c == 1) ? 16'(AM_IR) :
                        (r == 8 || r == 10) ? 16'(AM_RR) : 16'(AM_R));
                end
        send(8'h02, 8'h12, 8'h00);
        chk("len", 16'(len_q), 16'h1);
        send(8'h80, 8'h13, 8'h00);
        chk("odd pair", 16'(range_err_q), 16'h1);
        send(8'hC3, 8'h13, 8'h00);
        chk("odd wpair", 16'(range_err_q), 16'h1);
        send(8'hE3, 8'h15, 8'h00);
        chk("odd wpair step", 16'(range_err_q), 16'h1);
        send(8'hD5, 8'h24, 8'h00);
        chk("undef", 16'(undef_q), 16'h1);
        chk("undef op", 16'(op_q), 16'(OP_UNDEFINED));
        // Back to back: pass-through column then a decode
        @(posedge mclk);
        present <= 1'b1;
        f_opc <= 8'hF8;
        @(posedge mclk);
        f_opc <= 8'h02;
        #1;
        chk("pass", 16'(pass_q), 16'h1);
        chk("pass opc", 16'(pass_opc_q), 16'h00F8);
        chk("pass op", 16'(op_q), 16'(OP_NONE));
        chk("pass valid", 16'(valid_q), 16'h0);
        @(posedge mclk);
        present <= 1'b0;
        #1;
        good(OP_ADD);
        send(8'h0F, 8'h24, 8'h00);
        chk("pass", 16'(pass_q), 16'h1);
        // Mid-run reset clears the outputs at once, so load some first
        send(8'hD5, 8'h24, 8'h00);
        rst_b <= 1'b0;
        #1;
        chk("rst op", 16'(op_q), 16'(OP_NONE));
        chk("rst valid", 16'(valid_q), 16'h0);
        chk("rst undef", 16'(undef_q), 16'h0);
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        send(8'h02, 8'h24, 8'h00);
        good(OP_ADD);
        end_sim();
    end
endmodule : tb_top
